// File: btcc_pkg.sv
// constants, field layouts and bus carriers for the buffered timer compare core
// assumes a single 50 MHz clock and an AXI4-Lite master with 8-bit byte addresses
package btcc_pkg;

    localparam int CNT_W = 16;
    localparam int NCH = 3;
    localparam int ADDR_W = 8;
    localparam int PRE_W = 10;
    localparam real CLK_PERIOD_NS = 20.0;

    // byte addresses of the register words
    localparam logic [ADDR_W-1:0] ADDR_CONTROL_A = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL_B = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL_E = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL_F = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_EVENT_CONTROL = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_COUNTER = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD = 8'h1C;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD_BUFFER = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_COMPARE_BASE = 8'h24;
    localparam logic [ADDR_W-1:0] ADDR_COMPARE_BUF_BASE = 8'h30;
    localparam logic [ADDR_W-1:0] ADDR_LAST = 8'h38;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 8'h04;

    // field positions
    localparam int CA_ENABLE_BIT = 0;
    localparam int CA_PRESCALE_LSB = 1;
    localparam int CB_MODE_LSB = 0;
    localparam int CB_CMPEN_LSB = 4;
    localparam int CE_DIR_BIT = 0;
    localparam int CE_LOCK_BIT = 1;
    localparam int CF_PERIOD_BUFFER_VALID_BIT = 0;
    localparam int CF_CMPBV_LSB = 1;
    localparam int EV_ENABLE_BIT = 0;

    localparam logic [CNT_W-1:0] CNT_BOTTOM = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [CNT_W-1:0] PERIOD_RESET = 16'hFFFF;
    localparam logic [CNT_W-1:0] COMPARE_RESET = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        WGM_NORMAL = 3'h0,
        WGM_FREQUENCY = 3'h1
    } btcc_waveform_mode_e;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } btcc_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } btcc_axi_rsp_s;

    // divide ratios 1,2,4,8,16,64,256,1024 as low-bit masks of the prescaler
    function automatic logic [PRE_W-1:0] btcc_presc_mask(input logic [2:0] sel);
        case (sel)
            3'h0: btcc_presc_mask = 10'h000;
            3'h1: btcc_presc_mask = 10'h001;
            3'h2: btcc_presc_mask = 10'h003;
            3'h3: btcc_presc_mask = 10'h007;
            3'h4: btcc_presc_mask = 10'h00F;
            3'h5: btcc_presc_mask = 10'h03F;
            3'h6: btcc_presc_mask = 10'h0FF;
            default: btcc_presc_mask = 10'h3FF;
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] btcc_merge16(input logic [CNT_W-1:0] old, input logic [31:0] d,
                                                      input logic [3:0] strb);
        btcc_merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic btcc_addr_ok(input logic [ADDR_W-1:0] a);
        btcc_addr_ok = (a <= ADDR_LAST) && (a[1:0] == 2'h0);
    endfunction

endpackage

// File: btcc_core.sv
// 16-bit timer/counter with double-buffered period and three compare channels
// assumes one clock domain, an AXI4-Lite master and an asynchronous event pin
//
// Notes on behaviour
// - a count of 0x0000 is bottom.
// - all ones across sixteen bits is the maximum.
// - top is the highest value of the present count sequence.
// - update at top or bottom loads valid buffers unless update lock is set.
// - setting enable starts counting at the prescale select rate.
// - event input A enable makes events advance the counter instead of ticks.
// - counting follows the count sense bit until top or bottom.
// - counting up, top wraps to zero on the next tick.
// - counting down, bottom reloads the current period.
// - software counter write is immediate and beats count, clear, reload.
// - count sense may change while running; new direction applies at once.
// - each buffer has a valid flag, set on write, cleared at update.
// - compare and its buffer are both writable; direct write bypasses buffering.
// - unbuffered period writes act at once on the top comparison.
// - period below count when up means run to maximum and wrap first.
// - buffered period changes only at the update event.
// - compare match sets the channel flag at the clock edge of the matching tick, seen one clock later.
// - at update compare buffer moves to compare, used from next count.
// - pin override needs a waveform mode and the channel compare enable.
// - frequency mode takes its period from compare zero.
// - frequency mode toggles each channel output on its match.
// - counter, period, compare and buffers are sixteen bits.
// - trigger effects appear one timer clock after the trigger.
// - compare zero of zero, undivided, toggles every clock.
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module btcc_core (
    input wire logic sys_clk,
    input wire logic srst,
    input wire btcc_pkg::btcc_axi_req_s axi_req,
    output btcc_pkg::btcc_axi_rsp_s axi_rsp,
    input wire logic event_a_in,
    output logic [btcc_pkg::NCH-1:0] waveform_out_n,
    output logic [btcc_pkg::NCH-1:0] pin_override
);
    import btcc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // register state
    logic enable_reg;
    logic [2:0] prescale_select_reg;
    logic [2:0] waveform_mode_reg;
    logic [NCH-1:0] compare_output_enable_reg;
    logic count_down_reg;
    logic update_lock_reg;
    logic event_input_a_enable_reg;
    logic [CNT_W-1:0] counter_value_reg;
    logic [CNT_W-1:0] period_reg;
    logic [CNT_W-1:0] period_buffer_reg;
    logic period_buffer_valid_reg;
    logic [CNT_W-1:0] compare_value_reg [NCH];
    logic [CNT_W-1:0] compare_buffer_reg [NCH];
    logic [NCH-1:0] compare_buffer_valid_reg;
    logic [NCH-1:0] match_flag_reg;
    logic [NCH-1:0] wave_reg;
    logic [NCH-1:0] override_reg;
    logic [PRE_W-1:0] prescale_cnt_reg;
    logic ev_meta_reg, ev_sync_reg, ev_prev_reg;

    // bus state
    btcc_axi_rsp_s rsp_reg;
    logic aw_held_reg, w_held_reg;
    logic [ADDR_W-1:0] waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: address and data taken in either order, one write at a time
    logic wr_fire;
    logic [31:0] rd_val;
    logic rd_ok;
    assign wr_fire = aw_held_reg && w_held_reg && !rsp_reg.bvalid;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rsp_reg <= '0;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            waddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end else begin
            // each ready is high only while its own channel holds nothing, so outputs stay registered
            rsp_reg.awready <= !aw_held_reg && !(axi_req.awvalid && rsp_reg.awready);
            rsp_reg.wready <= !w_held_reg && !(axi_req.wvalid && rsp_reg.wready);
            if (axi_req.awvalid && rsp_reg.awready) begin
                aw_held_reg <= 1'b1;
                waddr_reg <= axi_req.awaddr;
            end
            if (axi_req.wvalid && rsp_reg.wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= axi_req.wdata;
                wstrb_reg <= axi_req.wstrb;
            end
            if (wr_fire) begin
                rsp_reg.bvalid <= 1'b1;
                rsp_reg.bresp <= btcc_addr_ok(waddr_reg) ? RESP_OKAY : RESP_SLVERR;
            end else if (rsp_reg.bvalid && axi_req.bready) begin
                rsp_reg.bvalid <= 1'b0;
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                rsp_reg.awready <= 1'b1;
                rsp_reg.wready <= 1'b1;
            end
            rsp_reg.arready <= !rsp_reg.rvalid && !(axi_req.arvalid && rsp_reg.arready);
            if (axi_req.arvalid && rsp_reg.arready) begin
                rsp_reg.rvalid <= 1'b1;
                rsp_reg.rdata <= rd_val;
                rsp_reg.rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (rsp_reg.rvalid && axi_req.rready) begin
                rsp_reg.rvalid <= 1'b0;
                rsp_reg.arready <= 1'b1;
            end
        end
    end
    assign axi_rsp = rsp_reg;

    // write strobes per register
    logic wr_ctrl_a, wr_ctrl_b, wr_ctrl_e, wr_evctl, wr_flags, wr_cnt, wr_per, wr_period_buffer;
    assign wr_ctrl_a = wr_fire && waddr_reg == ADDR_CONTROL_A;
    assign wr_ctrl_b = wr_fire && waddr_reg == ADDR_CONTROL_B;
    assign wr_ctrl_e = wr_fire && waddr_reg == ADDR_CONTROL_E;
    assign wr_evctl = wr_fire && waddr_reg == ADDR_EVENT_CONTROL;
    assign wr_flags = wr_fire && waddr_reg == ADDR_FLAGS && wstrb_reg[0];
    assign wr_cnt = wr_fire && waddr_reg == ADDR_COUNTER;
    assign wr_per = wr_fire && waddr_reg == ADDR_PERIOD;
    assign wr_period_buffer = wr_fire && waddr_reg == ADDR_PERIOD_BUFFER;

    always_comb begin
        rd_ok = btcc_addr_ok(axi_req.araddr);
        rd_val = '0;
        case (axi_req.araddr)
            ADDR_CONTROL_A: rd_val[3:0] = {prescale_select_reg, enable_reg};
            ADDR_CONTROL_B: rd_val[6:0] = {compare_output_enable_reg, 1'b0, waveform_mode_reg};
            ADDR_CONTROL_E: rd_val[1:0] = {update_lock_reg, count_down_reg};
            ADDR_CONTROL_F: rd_val[3:0] = {compare_buffer_valid_reg, period_buffer_valid_reg};
            ADDR_EVENT_CONTROL: rd_val[0] = event_input_a_enable_reg;
            ADDR_FLAGS: rd_val[NCH-1:0] = match_flag_reg;
            ADDR_COUNTER: rd_val[CNT_W-1:0] = counter_value_reg;
            ADDR_PERIOD: rd_val[CNT_W-1:0] = period_reg;
            ADDR_PERIOD_BUFFER: rd_val[CNT_W-1:0] = period_buffer_reg;
            default: begin
                for (int i = 0; i < NCH; i++) begin
                    if (axi_req.araddr == ADDR_COMPARE_BASE + ADDR_W'(i) * ADDR_STEP) begin
                        rd_val[CNT_W-1:0] = compare_value_reg[i];
                    end
                    if (axi_req.araddr == ADDR_COMPARE_BUF_BASE + ADDR_W'(i) * ADDR_STEP) begin
                        rd_val[CNT_W-1:0] = compare_buffer_reg[i];
                    end
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            enable_reg <= 1'b0;
            prescale_select_reg <= 3'h0;
            waveform_mode_reg <= WGM_NORMAL;
            compare_output_enable_reg <= '0;
            count_down_reg <= 1'b0;
            update_lock_reg <= 1'b0;
            event_input_a_enable_reg <= 1'b0;
        end else begin
            if (wr_ctrl_a && wstrb_reg[0]) begin
                enable_reg <= wdata_reg[CA_ENABLE_BIT];
                prescale_select_reg <= wdata_reg[CA_PRESCALE_LSB +: 3];
            end
            if (wr_ctrl_b && wstrb_reg[0]) begin
                waveform_mode_reg <= wdata_reg[CB_MODE_LSB +: 3];
                compare_output_enable_reg <= wdata_reg[CB_CMPEN_LSB +: NCH];
            end
            if (wr_ctrl_e && wstrb_reg[0]) begin
                count_down_reg <= wdata_reg[CE_DIR_BIT];
                update_lock_reg <= wdata_reg[CE_LOCK_BIT];
            end
            if (wr_evctl && wstrb_reg[0]) begin
                event_input_a_enable_reg <= wdata_reg[EV_ENABLE_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timer clock: prescaled ticks or synchronised event edges
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ev_meta_reg <= 1'b0;
            ev_sync_reg <= 1'b0;
            ev_prev_reg <= 1'b0;
        end else begin
            ev_meta_reg <= event_a_in;
            ev_sync_reg <= ev_meta_reg;
            ev_prev_reg <= ev_sync_reg;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || !enable_reg) begin
            prescale_cnt_reg <= '0;
        end else begin
            prescale_cnt_reg <= prescale_cnt_reg + PRE_W'(1);
        end
    end

    logic presc_tick, tick;
    logic [PRE_W-1:0] presc_mask;
    assign presc_mask = btcc_presc_mask(prescale_select_reg);
    assign presc_tick = (prescale_cnt_reg & presc_mask) == presc_mask;
    assign tick = enable_reg && (event_input_a_enable_reg ? (ev_sync_reg && !ev_prev_reg) : presc_tick);

    ////////////////////////////////////////////////////////////////////////////
    // counter and update condition
    logic freq_mode, at_bottom, at_top, update_evt, update_go;
    logic [CNT_W-1:0] top_val;
    assign freq_mode = waveform_mode_reg == WGM_FREQUENCY;
    assign top_val = freq_mode ? compare_value_reg[0] : period_reg;
    assign at_bottom = counter_value_reg == CNT_BOTTOM;
    assign at_top = counter_value_reg == top_val;
    assign update_evt = tick && (count_down_reg ? at_bottom : at_top);
    assign update_go = update_evt && !update_lock_reg;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            counter_value_reg <= CNT_BOTTOM;
        end else if (wr_cnt) begin
            counter_value_reg <= btcc_merge16(counter_value_reg, wdata_reg, wstrb_reg);
        end else if (tick) begin
            // count step; past max the adder wraps
            if (count_down_reg) begin
                counter_value_reg <= at_bottom ? top_val : counter_value_reg - CNT_W'(1);
            end else begin
                counter_value_reg <= at_top ? CNT_BOTTOM : counter_value_reg + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            period_reg <= PERIOD_RESET;
            period_buffer_reg <= PERIOD_RESET;
            period_buffer_valid_reg <= 1'b0;
        end else begin
            if (wr_per) begin
                period_reg <= btcc_merge16(period_reg, wdata_reg, wstrb_reg);
            end else if (update_go && period_buffer_valid_reg) begin
                period_reg <= period_buffer_reg;
            end
            if (wr_period_buffer) begin
                period_buffer_reg <= btcc_merge16(period_buffer_reg, wdata_reg, wstrb_reg);
            end
            if (wr_period_buffer) begin
                period_buffer_valid_reg <= 1'b1;
            end else if (update_go) begin
                period_buffer_valid_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // compare channels
    genvar n;
    generate
        for (n = 0; n < NCH; n++) begin : g_ch
            localparam logic [ADDR_W-1:0] A_CMP = ADDR_COMPARE_BASE + ADDR_W'(n) * ADDR_STEP;
            localparam logic [ADDR_W-1:0] A_BUF = ADDR_COMPARE_BUF_BASE + ADDR_W'(n) * ADDR_STEP;
            logic wr_cmp, wr_buf, match;
            assign wr_cmp = wr_fire && waddr_reg == A_CMP;
            assign wr_buf = wr_fire && waddr_reg == A_BUF;
            assign match = tick && counter_value_reg == compare_value_reg[n];

            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    compare_value_reg[n] <= COMPARE_RESET;
                    compare_buffer_reg[n] <= COMPARE_RESET;
                    compare_buffer_valid_reg[n] <= 1'b0;
                end else begin
                    if (wr_cmp) begin
                        compare_value_reg[n] <= btcc_merge16(compare_value_reg[n], wdata_reg, wstrb_reg);
                    end else if (update_go && compare_buffer_valid_reg[n]) begin
                        compare_value_reg[n] <= compare_buffer_reg[n];
                    end
                    if (wr_buf) begin
                        compare_buffer_reg[n] <= btcc_merge16(compare_buffer_reg[n], wdata_reg, wstrb_reg);
                    end
                    if (wr_buf) begin
                        compare_buffer_valid_reg[n] <= 1'b1;
                    end else if (update_go) begin
                        compare_buffer_valid_reg[n] <= 1'b0;
                    end
                end
            end

            // sticky flag, set wins over write-one clear
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    match_flag_reg[n] <= 1'b0;
                end else if (match) begin
                    match_flag_reg[n] <= 1'b1;
                end else if (wr_flags && wdata_reg[n]) begin
                    match_flag_reg[n] <= 1'b0;
                end
            end

            // frequency toggle; other modes hold the level
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    wave_reg[n] <= 1'b0;
                end else if (match && freq_mode) begin
                    wave_reg[n] <= !wave_reg[n];
                end
            end

            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    override_reg[n] <= 1'b0;
                end else begin
                    override_reg[n] <= compare_output_enable_reg[n] && waveform_mode_reg != WGM_NORMAL;
                end
            end
        end
    endgenerate
    assign waveform_out_n = wave_reg;
    assign pin_override = override_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence s_up_top;
        tick && !count_down_reg && at_top && !wr_cnt;
    endsequence
    sequence s_down_bottom;
        tick && count_down_reg && at_bottom && !wr_cnt;
    endsequence
    sequence s_up_max;
        tick && !count_down_reg && !at_top && counter_value_reg == CNT_MAX && !wr_cnt;
    endsequence

    a_top_wrap_zero: assert property (s_up_top |=> counter_value_reg == CNT_BOTTOM)
        else $error("counter did not wrap to zero after top");
    a_max_wrap_zero: assert property (s_up_max |=> counter_value_reg == CNT_BOTTOM)
        else $error("counter did not wrap past maximum");
    a_bottom_reload_top: assert property (s_down_bottom |=> counter_value_reg == $past(top_val))
        else $error("counter did not reload from period at bottom");
    a_cnt_write_wins: assert property (wr_cnt && wstrb_reg == 4'hF |=> counter_value_reg == $past(wdata_reg[15:0]))
        else $error("counter write not immediate");
    a_idle_counter_stable: assert property (!enable_reg && !wr_cnt |=> $stable(counter_value_reg))
        else $error("counter moved while disabled");
    a_update_load_period: assert property (update_go && period_buffer_valid_reg && !wr_per && !wr_period_buffer
                                           |=> period_reg == $past(period_buffer_reg) && !period_buffer_valid_reg)
        else $error("period not loaded from buffer at update");
    a_lock_holds_period: assert property (update_evt && update_lock_reg && !wr_per && !wr_period_buffer
                                          |=> $stable(period_reg) && $stable(period_buffer_valid_reg))
        else $error("period changed under update lock");
    a_buf_valid_set: assert property (wr_period_buffer |=> period_buffer_valid_reg)
        else $error("period buffer valid not set on write");
    a_match_flag_next: assert property (tick && counter_value_reg == compare_value_reg[0]
                                        |=> match_flag_reg[0])
        else $error("compare flag not set one cycle after match");
    a_freq_wave_toggle: assert property (tick && freq_mode && counter_value_reg == compare_value_reg[1]
                                         |=> wave_reg[1] != $past(wave_reg[1]))
        else $error("frequency output did not toggle on match");
    a_no_toggle_idle: assert property (!tick ##1 1'b1 |-> $stable(wave_reg))
        else $error("waveform changed without a timer tick");
    a_override_follows: assert property (##1 override_reg[2] == $past(compare_output_enable_reg[2]
                                         && waveform_mode_reg != WGM_NORMAL))
        else $error("pin override does not follow enable and mode");
    a_half_rate_toggle: assert property (enable_reg && freq_mode && prescale_select_reg == 3'h0
                                         && !event_input_a_enable_reg && compare_value_reg[0] == CNT_BOTTOM
                                         && counter_value_reg == CNT_BOTTOM && !wr_fire
                                         |=> wave_reg[0] != $past(wave_reg[0]))
        else $error("output not toggling every clock at fastest setting");

endmodule

// File: btcc_far_side.sv
// far-side model: event source on the count pin, watcher of waveform pin 0
// assumes the bench calls send_events right after a clock edge
`timescale 1ns/1ps
module btcc_far_side (
    input wire logic sys_clk,
    output logic event_a_in,
    input wire logic [btcc_pkg::NCH-1:0] waveform_out_n,
    input wire logic [btcc_pkg::NCH-1:0] pin_override
);
    import btcc_pkg::*;
    int toggles = 0;
    logic last_w = 1'b0;
    initial event_a_in = 1'b0;
    always @(posedge sys_clk) begin
        if (pin_override[0] && waveform_out_n[0] !== last_w) toggles <= toggles + 1;
        last_w <= waveform_out_n[0];
    end
    task automatic send_events(input int n);
        repeat (n) begin
            event_a_in <= 1'b1;
            repeat (4) @(posedge sys_clk);
            event_a_in <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
    endtask
endmodule

// File: buffered_timer_compare_core_tb_top.sv
// register-level bench for the timer core over AXI4-Lite
// assumes the far-side model drives the event pin
`timescale 1ns/1ps
module buffered_timer_compare_core_tb_top;
    import btcc_pkg::*;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    btcc_axi_req_s req = '0;
    btcc_axi_rsp_s rsp;
    logic event_a_in;
    logic [NCH-1:0] wave;
    logic [NCH-1:0] ovr;
    logic [31:0] rdat;
    logic [1:0] resp;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int t0;
    always #10 sys_clk = ~sys_clk;
    btcc_core btcc_core_inst (.sys_clk(sys_clk), .srst(srst), .axi_req(req), .axi_rsp(rsp),
        .event_a_in(event_a_in), .waveform_out_n(wave), .pin_override(ovr));
    btcc_far_side btcc_far_side_inst (.sys_clk(sys_clk), .event_a_in(event_a_in),
        .waveform_out_n(wave), .pin_override(ovr));
    ////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
    endtask
    task automatic rd(input logic [7:0] a);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        rdat = rsp.rdata;
        resp = rsp.rresp;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(rdat, exp);
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        rc(ADDR_PERIOD, 32'h0000FFFF);
        rc(8'h3C, 32'h00000000);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        $display("reset and map test done");
        wr(ADDR_PERIOD, 32'h00000002);
        wr(ADDR_PERIOD_BUFFER, 32'h00000007);
        rc(ADDR_CONTROL_F, 32'h00000001);
        rc(ADDR_PERIOD, 32'h00000002);
        wr(ADDR_COUNTER, 32'h00000000);
        wr(ADDR_EVENT_CONTROL, 32'h00000001);
        wr(ADDR_CONTROL_A, 32'h00000001);
        btcc_far_side_inst.send_events(3);
        rc(ADDR_COUNTER, 32'h00000000);
        rc(ADDR_PERIOD, 32'h00000007);
        rc(ADDR_CONTROL_F, 32'h00000000);
        wr(ADDR_CONTROL_E, 32'h00000001);
        btcc_far_side_inst.send_events(1);
        rc(ADDR_COUNTER, 32'h00000007);
        wr(ADDR_COUNTER, 32'h00000005);
        rc(ADDR_COUNTER, 32'h00000005);
        $display("event count test done");
        wr(ADDR_EVENT_CONTROL, 32'h00000000);
        wr(ADDR_CONTROL_E, 32'h00000000);
        wr(ADDR_CONTROL_B, 32'h00000011);
        wr(ADDR_COUNTER, 32'h00000000);
        repeat (4) @(posedge sys_clk);
        t0 = btcc_far_side_inst.toggles;
        repeat (10) @(posedge sys_clk);
        chk(btcc_far_side_inst.toggles - t0, 32'd10);
        rc(ADDR_FLAGS, 32'h00000007);
        $display("frequency test done");
        wr(ADDR_CONTROL_A, 32'h00000000);
        wr(ADDR_COMPARE_BUF_BASE + 8'h04, 32'h00001234);
        rc(ADDR_CONTROL_F, 32'h00000004);
        rc(ADDR_COMPARE_BASE + 8'h04, 32'h00000000);
        wr(ADDR_COMPARE_BASE + 8'h08, 32'h00000055);
        rc(ADDR_COMPARE_BASE + 8'h08, 32'h00000055);
        wr(ADDR_CONTROL_A, 32'h00000003);
        repeat (4) @(posedge sys_clk);
        t0 = btcc_far_side_inst.toggles;
        repeat (20) @(posedge sys_clk);
        chk(btcc_far_side_inst.toggles - t0, 32'd10);
        rc(ADDR_COMPARE_BASE + 8'h04, 32'h00001234);
        rc(ADDR_CONTROL_F, 32'h00000000);
        $display("compare buffer test done");
        wr(ADDR_CONTROL_A, 32'h00000000);
        wr(ADDR_CONTROL_B, 32'h00000000);
        wr(ADDR_EVENT_CONTROL, 32'h00000001);
        wr(ADDR_COUNTER, 32'h0000FFFE);
        wr(ADDR_PERIOD, 32'h00000005);
        wr(ADDR_CONTROL_A, 32'h00000001);
        btcc_far_side_inst.send_events(3);
        rc(ADDR_COUNTER, 32'h00000001);
        $display("wrap test done");
        give_verdict();
    end
endmodule
